/* File: core/sram_cycle_pkg.sv */
package sram_cycle_pkg;

  localparam int ADDR_W = 17;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int PAR_BASE = 32;
  localparam int BEAT_W = 2;
  localparam int MEM_WORDS = 131072;
  localparam int TAP_DEPTH = 32;
  localparam int PIPE_DEPTH = 2;
  localparam logic [BEAT_W-1:0] BEAT_START = 2'h0;
  localparam logic [BEAT_W-1:0] BEAT_STEP = 2'h1;
  localparam logic [LANES-1:0] NO_LANES = 4'h0;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h0;

  // Burst direction tracker; one bit flips along idle, read, write
  typedef enum logic [1:0] {
    BURST_IDLE = 2'b00,
    BURST_RD = 2'b01,
    BURST_WR = 2'b11
  } burst_st_t;

  typedef struct packed {
    logic valid;
    logic wr;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] lane_en;
  } stage_t;

  localparam stage_t STAGE_RST = '{valid: 1'b0, wr: 1'b0,
                                   addr: 17'h0, lane_en: 4'h0};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } tap_t;

  localparam int TAP_W = ADDR_W + DATA_W;

endpackage : sram_cycle_pkg

/* File: core/beat_fifo.sv */
`timescale 1ns/10ps
`default_nettype none
module beat_fifo #(
  parameter int WIDTH = 53,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W:0] FULL_CNT = (PTR_W+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wptr_ff;
  logic [PTR_W-1:0] rptr_ff;
  logic [PTR_W:0] cnt_ff;
  logic room_ff;
  logic avail_ff;
  wire push = in_valid_i & room_ff;
  wire pop = out_ready_i & avail_ff;
  wire [PTR_W:0] nxt_cnt = cnt_ff + (PTR_W+1)'(push) - (PTR_W+1)'(pop);

  assign in_ready_o = room_ff;
  assign out_valid_o = avail_ff;
  assign out_data_o = mem[rptr_ff];

  always_ff @(posedge ref_clk_i)
  begin
    if (clk_en_i && push)
      mem[wptr_ff] <= in_data_i;
  end

  // Flags registered so full and empty never glitch on the ports
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
      room_ff <= 1'b1;
      avail_ff <= 1'b0;
    end
    else if (clk_en_i)
    begin
      wptr_ff <= wptr_ff + PTR_W'(push);
      rptr_ff <= rptr_ff + PTR_W'(pop);
      cnt_ff <= nxt_cnt;
      room_ff <= (nxt_cnt != FULL_CNT);
      avail_ff <= (nxt_cnt != '0);
    end
  end

endmodule : beat_fifo
`default_nettype wire

/* File: core/sram_cycle_ctrl.sv */
// How it works
// - Selected load, direction low: write, data later
// - Selected load, direction high: read data later
// - Advance sampled high bumps counter, next beat
// - Advance ignores direction and selects
// - Burst keeps direction from its load
// - Deselect stops; advance afterwards is idle
// - Data bus floats two cycles after deselect
// - Suspended edge changes nothing at all
// - Selected only when all three selects true
// - Data bus floats from power-up until read
// - Low strobe writes its lane, reads ignore
// - Any strobe mix updates lanes together
// - Order high: start xor beat count
// - Order low: start plus count modulo four
// - Counter wraps after fourth beat, continues
`timescale 1ns/10ps
`default_nettype none
module sram_cycle_ctrl
  import sram_cycle_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic suspend_gate_n_i,
  input wire logic advance_or_load_i,
  input wire logic read_not_write_i,
  input wire logic select_low_a_n_i,
  input wire logic select_low_b_n_i,
  input wire logic select_high_i,
  input wire logic burst_order_select_i,
  input wire logic [LANES-1:0] byte_lane_strobe_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic tap_room_o,
  output logic tap_valid_o,
  input wire logic tap_ready_i,
  output logic [TAP_W-1:0] tap_data_o
);

  logic [DATA_W-1:0] mem [MEM_WORDS];
  stage_t s1_ff;
  stage_t s2_ff;
  stage_t nxt_s1;
  burst_st_t burst_st_ff;
  burst_st_t nxt_burst_st;
  logic [ADDR_W-1:0] base_ff;
  logic [BEAT_W-1:0] cnt_ff;
  logic [DATA_W-1:0] rd_data_ff;
  logic [DATA_W-1:0] dq_ff;
  logic dq_oe_ff;
  logic tap_room;
  tap_t tap_in;

  // Suspend pin and block enable together gate every edge
  // one enable for all
  wire cke = clk_en_i & ~suspend_gate_n_i;

  wire selected = ~select_low_a_n_i & ~select_low_b_n_i & select_high_i;
  wire is_adv = advance_or_load_i;
  wire load_rd = ~is_adv & selected & read_not_write_i;
  wire load_wr = ~is_adv & selected & ~read_not_write_i;
  wire load_any = load_rd | load_wr;
  wire desel = ~is_adv & ~selected;
  wire adv_go = is_adv & (burst_st_ff != BURST_IDLE);
  wire burst_wr = (burst_st_ff == BURST_WR);

  wire [BEAT_W-1:0] nxt_cnt = cnt_ff + BEAT_STEP;
  wire [BEAT_W-1:0] low_ilv = base_ff[BEAT_W-1:0] ^ nxt_cnt;
  wire [BEAT_W-1:0] low_lin = base_ff[BEAT_W-1:0] + nxt_cnt;
  wire [BEAT_W-1:0] adv_low = burst_order_select_i ? low_ilv : low_lin;
  wire [ADDR_W-1:0] adv_addr = {base_ff[ADDR_W-1:BEAT_W], adv_low};

  wire cmd_wr = load_any ? load_wr : burst_wr;
  wire [LANES-1:0] cmd_lanes = cmd_wr ? ~byte_lane_strobe_n_i : NO_LANES;

  always_comb
  begin
    nxt_s1 = STAGE_RST;
    nxt_s1.valid = load_any | adv_go;
    nxt_s1.wr = cmd_wr & nxt_s1.valid;
    nxt_s1.addr = load_any ? addr_i : adv_addr;
    nxt_s1.lane_en = nxt_s1.valid ? cmd_lanes : NO_LANES;
  end

  always_comb
  begin
    nxt_burst_st = burst_st_ff;
    case (burst_st_ff)
      BURST_IDLE, BURST_RD, BURST_WR:
      begin
        if (load_rd)
          nxt_burst_st = BURST_RD;
        else if (load_wr)
          nxt_burst_st = BURST_WR;
        else if (desel)
          nxt_burst_st = BURST_IDLE;
      end
      // Unused code falls back to idle rather than lock up
      default:
        nxt_burst_st = BURST_IDLE;
    endcase
  end

  // A write in stage two lands on the same edge a read samples the
  // array, so forward its lanes to avoid returning stale data
  wire fwd_hit = s2_ff.valid & s2_ff.wr & (s2_ff.addr == s1_ff.addr);

  function automatic logic [DATA_W-1:0] lane_merge(
    input logic [DATA_W-1:0] old_word,
    input logic [DATA_W-1:0] new_word,
    input logic [LANES-1:0] en
  );
    logic [DATA_W-1:0] res;
    res = old_word;
    for (int k = 0; k < LANES; k++)
    begin
      if (en[k])
      begin
        res[k*BYTE_W +: BYTE_W] = new_word[k*BYTE_W +: BYTE_W];
        res[PAR_BASE+k] = new_word[PAR_BASE+k];
      end
    end
    return res;
  endfunction : lane_merge

  wire [LANES-1:0] fwd_lanes = fwd_hit ? s2_ff.lane_en : NO_LANES;
  wire [DATA_W-1:0] rd_word = lane_merge(mem[s1_ff.addr], dq_i, fwd_lanes);
  wire commit_wr = cke & s2_ff.valid & s2_ff.wr;
  wire rd_done = s2_ff.valid & ~s2_ff.wr;

  // write data taken at stage two
  always_ff @(posedge ref_clk_i)
  begin
    if (commit_wr)
      mem[s2_ff.addr] <= lane_merge(mem[s2_ff.addr], dq_i, s2_ff.lane_en);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_ff <= STAGE_RST;
      s2_ff <= STAGE_RST;
    end
    else if (cke)
    begin
      s1_ff <= nxt_s1;
      s2_ff <= s1_ff;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      burst_st_ff <= BURST_IDLE;
      base_ff <= '0;
      cnt_ff <= BEAT_START;
    end
    else if (cke)
    begin
      burst_st_ff <= nxt_burst_st;
      if (load_any)
      begin
        base_ff <= addr_i;
        cnt_ff <= BEAT_START;
      end
      else if (adv_go)
        cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      rd_data_ff <= DATA_RST;
    else if (cke && s1_ff.valid && !s1_ff.wr)
      rd_data_ff <= rd_word;
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dq_ff <= DATA_RST;
      dq_oe_ff <= 1'b0;
    end
    else if (cke)
    begin
      dq_oe_ff <= rd_done;
      if (rd_done)
        dq_ff <= rd_data_ff;
    end
  end

  assign dq_o = dq_ff;
  assign dq_oe_o = dq_oe_ff;

  // Read beats copied to a side stream; a full buffer drops copies
  // rather than stall the bus, whose timing is fixed
  assign tap_in = '{addr: s2_ff.addr, data: rd_data_ff};

  beat_fifo #(
    .WIDTH(TAP_W),
    .DEPTH(TAP_DEPTH)
  ) u_tap_fifo (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .clk_en_i(cke),
    .in_valid_i(rd_done),
    .in_ready_o(tap_room),
    .in_data_i(tap_in),
    .out_valid_o(tap_valid_o),
    .out_ready_i(tap_ready_i),
    .out_data_o(tap_data_o)
  );

  assign tap_room_o = tap_room;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence load_rd_seq;
    cke && load_rd;
  endsequence

  sequence two_live_edges;
    cke ##1 cke;
  endsequence

  sequence desel_seq;
    cke && desel;
  endsequence

  sequence load_wr_seq;
    cke && load_wr;
  endsequence

  a_load_read_stage: assert property (
    load_rd_seq |=> s1_ff.valid && !s1_ff.wr && s1_ff.addr == $past(addr_i))
    else $error("load read not staged");

  a_read_data_out: assert property (
    load_rd_seq ##1 two_live_edges |=> dq_oe_ff)
    else $error("read data not driven two cycles on");

  a_load_write_stage: assert property (
    cke && load_wr |=> s1_ff.valid && s1_ff.wr
      && s1_ff.lane_en == ~$past(byte_lane_strobe_n_i))
    else $error("load write not staged");

  a_burst_count: assert property (
    cke && adv_go |=> cnt_ff == $past(cnt_ff) + BEAT_STEP && s1_ff.valid)
    else $error("burst counter did not advance");

  a_burst_dir_kept: assert property (
    cke && adv_go |=> s1_ff.wr == $past(burst_wr))
    else $error("burst direction changed");

  a_idle_cycle_after_stop: assert property (
    cke && is_adv && burst_st_ff == BURST_IDLE |=> !s1_ff.valid)
    else $error("advance after stop moved data");

  a_deselect_hiz: assert property (
    desel_seq ##1 two_live_edges |=> !dq_oe_ff)
    else $error("bus still driven after deselect");

  a_suspend_hold: assert property (
    !cke |=> $stable(s1_ff) && $stable(s2_ff) && $stable(cnt_ff)
      && $stable(dq_oe_ff) && $stable(dq_ff))
    else $error("state moved during suspend");

  a_select_and: assert property (
    cke && !is_adv && !selected |=> !s1_ff.valid)
    else $error("deselected cycle started a transfer");

  a_oe_cause: assert property (
    dq_oe_ff |-> $past(rd_done) || $past(!cke))
    else $error("bus driven without a read");

  a_read_lanes_off: assert property (
    s1_ff.valid && !s1_ff.wr |-> s1_ff.lane_en == NO_LANES)
    else $error("read carries write lanes");

  a_order_interleave: assert property (
    cke && adv_go && burst_order_select_i
      |=> s1_ff.addr[BEAT_W-1:0] == (base_ff[BEAT_W-1:0] ^ cnt_ff))
    else $error("interleaved order wrong");

  a_order_linear: assert property (
    cke && adv_go && !burst_order_select_i
      |=> s1_ff.addr[BEAT_W-1:0] == base_ff[BEAT_W-1:0] + cnt_ff)
    else $error("linear order wrong");

  a_pending_done: assert property (
    cke && s1_ff.valid && !s1_ff.wr ##1 cke |=> dq_oe_ff)
    else $error("pending read lost after deselect");

  a_dir_ignored: assert property (
    cke && is_adv && burst_st_ff == BURST_RD |=> s1_ff.valid && !s1_ff.wr)
    else $error("advance took direction from pins");

  a_burst_wrap: assert property (
    cke && adv_go && cnt_ff == BEAT_START - BEAT_STEP
      |=> cnt_ff == BEAT_START)
    else $error("burst counter did not wrap");

  a_read_word_out: assert property (
    cke && s1_ff.valid && !s1_ff.wr ##1 cke |=> dq_ff == $past(rd_data_ff))
    else $error("read word not presented");

  a_write_commit: assert property (
    load_wr_seq ##1 cke |=> s2_ff.valid && s2_ff.wr)
    else $error("write load did not reach commit stage");

  a_write_float: assert property (
    load_wr_seq ##1 two_live_edges |=> !dq_oe_ff)
    else $error("bus driven after a write load");

  a_stage_shift: assert property (
    cke |=> s2_ff == $past(s1_ff))
    else $error("stage two lost a pending transfer");

  a_tap_push: assert property (
    cke && rd_done && tap_room |=> tap_valid_o)
    else $error("read beat not copied to tap");

endmodule : sram_cycle_ctrl
`default_nettype wire

/* File: dv/sram_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module sram_host_model
  import sram_cycle_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic live_i,
  output logic adv_o,
  output logic rnw_o,
  output logic [2:0] sel_o,
  output logic [LANES-1:0] strb_o,
  output logic [ADDR_W-1:0] addr_o,
  output logic [DATA_W-1:0] dq_o
);
  logic [DATA_W-1:0] wd = '0;
  logic [DATA_W:0] p1 = '0;
  logic [DATA_W:0] p2 = '0;
  logic wburst = 1'b0;
  initial
  begin
    adv_o = 1'b0;
    rnw_o = 1'b0;
    sel_o = 3'h6;
    strb_o = 4'hF;
    addr_o = '0;
    dq_o = '0;
  end
  task issue(input logic adv, input logic rnw, input logic [2:0] sel,
    input logic [LANES-1:0] s, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    adv_o = adv;
    rnw_o = rnw;
    sel_o = sel;
    // lane strobes held with the command
    strb_o = s;
    addr_o = a;
    wd = d;
  endtask : issue
  always @(posedge ref_clk_i)
    if (live_i)
    begin
      if (!adv_o)
        wburst = (sel_o == 3'h1) && !rnw_o;
      p2 = p1;
      p1 = {wburst, wd};
      #1;
      // write data two live edges on; bus otherwise toggles
      dq_o = p2[DATA_W] ? p2[DATA_W-1:0] : ~dq_o;
    end
endmodule : sram_host_model
`default_nettype wire

/* File: dv/zero_turnaround_sram_cycle_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module zero_turnaround_sram_cycle_control_bench;
  import sram_cycle_pkg::*;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [LANES-1:0] en;
    logic [ADDR_W-1:0] a;
    logic [DATA_W-1:0] d;
  } op_t;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic susp_n = 1'b0;
  logic burst_order_select_i = 1'b0;
  logic tap_ready_i = 1'b0;
  logic adv;
  logic rnw;
  logic [2:0] sel;
  logic [LANES-1:0] strb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] dq_i;
  logic [DATA_W-1:0] dq_o;
  logic dq_oe_o;
  logic tap_room_o;
  logic tap_valid_o;
  logic [TAP_W-1:0] tap_data_o;
  logic [DATA_W-1:0] mem [int];
  op_t pipe [2] = '{default: '0};
  logic open = 1'b0;
  logic dir = 1'b0;
  logic exp_oe = 1'b0;
  logic [DATA_W-1:0] exp_q = '0;
  logic [BEAT_W-1:0] k = '0;
  logic [ADDR_W-1:0] base = '0;
  int failures = 0;
  int compares = 0;
  wire live = clk_en_i & ~susp_n;
  always #2 ref_clk_i = ~ref_clk_i;
  sram_host_model sram_host_model_inst (.ref_clk_i(ref_clk_i),
    .live_i(live), .adv_o(adv), .rnw_o(rnw), .sel_o(sel), .strb_o(strb),
    .addr_o(addr), .dq_o(dq_i));
  sram_cycle_ctrl sram_cycle_ctrl_inst (.ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i), .clk_en_i(clk_en_i), .suspend_gate_n_i(susp_n),
    .advance_or_load_i(adv), .read_not_write_i(rnw),
    .select_low_a_n_i(sel[2]), .select_low_b_n_i(sel[1]),
    .select_high_i(sel[0]), .burst_order_select_i(burst_order_select_i),
    .byte_lane_strobe_n_i(strb), .addr_i(addr), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .tap_room_o(tap_room_o), .tap_valid_o(tap_valid_o),
    .tap_ready_i(tap_ready_i), .tap_data_o(tap_data_o));
  task chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      failures++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task final_report;
    $display("failures=%0d compares=%0d", failures, compares);
    if (failures == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  // Reference pipeline; expectations move only on live edges
  task step(input logic ad, input logic rw, input logic [2:0] se,
    input logic [LANES-1:0] s, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    op_t cur;
    op_t m;
    sram_host_model_inst.issue(ad, rw, se, s, a, d);
    @(posedge ref_clk_i);
    if (live)
    begin
      cur = '0;
      if (!ad && se == 3'h1)
      begin
        open = 1'b1;
        dir = ~rw;
        base = a;
        k = BEAT_START;
        cur.a = a;
      end
      else if (!ad)
        open = 1'b0;
      else if (open)
      begin
        k = k + BEAT_STEP;
        cur.a = {base[ADDR_W-1:2],
          burst_order_select_i ? base[1:0] ^ k : base[1:0] + k};
      end
      cur.rd = open & ~dir;
      cur.wr = open & dir;
      cur.en = ~s;
      cur.d = d;
      m = pipe[1];
      pipe[1] = pipe[0];
      pipe[0] = cur;
      if (m.wr)
        for (int i = 0; i < LANES; i++)
          if (m.en[i])
          begin
            mem[m.a][i*BYTE_W +: BYTE_W] = m.d[i*BYTE_W +: BYTE_W];
            mem[m.a][PAR_BASE+i] = m.d[PAR_BASE+i];
          end
      exp_oe = m.rd;
      if (m.rd)
        exp_q = mem[m.a];
    end
    #1;
    chk(dq_oe_o === exp_oe, "bus enable");
    if (exp_oe)
      chk(dq_o === exp_q, "read data");
  endtask : step
  task desel(input int n);
    repeat (n) step(1'b0, 1'b0, 3'h6, 4'h0, 17'h0, 36'h0);
  endtask : desel
  task s_write;
    step(0, 0, 3'h1, 4'h0, 17'h100, 36'h911111111);
    step(1, 1, 3'h6, 4'h0, 17'h0, 36'hA22222222);
    step(1, 1, 3'h6, 4'h0, 17'h0, 36'h533333333);
    step(1, 1, 3'h0, 4'h0, 17'h0, 36'h644444444);
    step(0, 0, 3'h1, 4'h5, 17'h102, 36'hFDDDDCCCC);
    step(1, 0, 3'h1, 4'hF, 17'h0, 36'h0);
    step(1, 0, 3'h1, 4'h0, 17'h0, 36'h7ABCDEF01);
    step(1, 0, 3'h1, 4'h6, 17'h0, 36'hC87654321);
    step(0, 1, 3'h1, 4'h0, 17'h101, 36'h0);
    repeat (3) step(1, 0, 3'h6, 4'h0, 17'h0, 36'h0);
    desel(3);
  endtask : s_write
  task s_inter;
    burst_order_select_i = 1'b1;
    step(0, 1, 3'h1, 4'h0, 17'h101, 36'h0);
    repeat (5) step(1, 0, 3'h0, 4'h0, 17'h0, 36'h0);
    desel(1);
    step(1, 1, 3'h1, 4'h0, 17'h0, 36'h0);
    desel(3);
    burst_order_select_i = 1'b0;
  endtask : s_inter
  task s_select;
    for (int i = 0; i < 8; i++)
    begin
      step(0, 1, i[2:0], 4'h0, 17'h103, 36'h0);
      desel(2);
    end
  endtask : s_select
  task s_suspend;
    step(0, 1, 3'h1, 4'h0, 17'h100, 36'h0);
    step(1, 0, 3'h0, 4'h0, 17'h0, 36'h0);
    susp_n = 1'b1;
    repeat (2) step(0, 1, 3'h1, 4'h0, 17'h102, 36'h0);
    susp_n = 1'b0;
    clk_en_i = 1'b0;
    step(1, 0, 3'h1, 4'h0, 17'h0, 36'h0);
    clk_en_i = 1'b1;
    step(1, 0, 3'h1, 4'h0, 17'h0, 36'h0);
    desel(3);
  endtask : s_suspend
  task s_tap;
    int n;
    n = 0;
    tap_ready_i = 1'b1;
    desel(40);
    chk(tap_valid_o === 1'b0, "tap drained");
    tap_ready_i = 1'b0;
    repeat (34) step(0, 1, 3'h1, 4'h0, 17'h100, 36'h0);
    desel(3);
    chk(tap_room_o === 1'b0, "tap full");
    chk(tap_data_o === {17'h100, mem[17'h100]}, "tap entry");
    tap_ready_i = 1'b1;
    repeat (40)
    begin
      if (tap_valid_o === 1'b1)
        n++;
      desel(1);
    end
    chk(n == TAP_DEPTH && tap_room_o === 1'b1, "tap count");
  endtask : s_tap
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    #1;
    arst_n_i = 1'b1;
    desel(3);
    s_write();
    s_inter();
    s_select();
    s_suspend();
    s_tap();
    final_report();
  end
  // Whole run needs well under 1 us
  initial
  begin
    #20000;
    failures++;
    final_report();
  end
endmodule : zero_turnaround_sram_cycle_control_bench
`default_nettype wire
